// ### hw/supervisor_pkg.sv
// Purpose: Shared constants and state type of the supervisor block.
// Assumes: Timebase clock at 40 MHz; times given in milliseconds.
// Notes: Cycle counts derive from the printed times and the clock rate.
package supervisor_pkg;
    // Timebase
    localparam int CLK_KHZ = 40000;
    localparam int CNT_W = 26;
    // Printed times
    localparam int RELEASE_MS = 200;
    localparam int MIN_PULSE_MS = 140;
    localparam int WDOG_MS = 1600;
    // Derived cycle counts
    localparam logic [CNT_W-1:0] RELEASE_CYCLES =
        CNT_W'(RELEASE_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] MIN_PULSE_CYCLES =
        CNT_W'(MIN_PULSE_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] WDOG_CYCLES =
        CNT_W'(WDOG_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Reset sequencing phases
    typedef enum logic [1:0] {
        PH_HOLD,
        PH_STRETCH,
        PH_RUN
    } phase_t;

    // Complete state of the block
    typedef struct packed {
        phase_t phase;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] total_cnt;
        logic rst_n;
        logic pf_n;
        logic kick_prev;
        logic wd_armed;
        logic [CNT_W-1:0] wd_cnt;
        logic wd_expired;
        logic wdo_n;
    } state_t;
endpackage

// ### hw/supervisor_reset_watchdog.sv
// Purpose: Processor supervisor: reset generator, watchdog, power-fail flag.
// Assumes: Supply and auxiliary comparators arrive as synchronous inputs.
// Notes: All durations are counted on CORE_CLK; long counts are parameters.
//
// Behaviour
// - Active-high reset output is always the exact inverse of active-low.
// - Reset holds while supply is low; releases about 200ms after rise.
// - Supply falling low during power-down asserts reset at once.
// - A brownout during normal operation produces a reset pulse.
// - Brownout during a reset pulse restarts the 200ms release delay.
// - Power-fail flag is low when comparator input below 1.25V.
// - Manual reset low starts a reset of at least 140ms.
// - No kick activity within 1.6 seconds drives watchdog output low.
// - Watchdog output stays low until a new kick transition, a floating kick or a reset.
// - Floating kick input keeps the watchdog counter cleared and stopped.
// - Asserted reset keeps the watchdog counter disabled and cleared.
// - First kick transition after reset release starts a 1.6s countdown.
// - Each further kick transition restarts a full-length countdown.
// - Low supply forces the watchdog output low regardless of counter.
// - Supply recovery releases watchdog output high at once.
// - Reset stays asserted 200ms after manual reset or supply recovers.
`timescale 1ns/100ps

module supervisor_reset_watchdog #(
    parameter logic [supervisor_pkg::CNT_W-1:0] RELEASE_CYCLES =
        supervisor_pkg::RELEASE_CYCLES,
    parameter logic [supervisor_pkg::CNT_W-1:0] MIN_PULSE_CYCLES =
        supervisor_pkg::MIN_PULSE_CYCLES,
    parameter logic [supervisor_pkg::CNT_W-1:0] WDOG_CYCLES =
        supervisor_pkg::WDOG_CYCLES
) (
    // Timebase and power-on reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Analog monitor results
    input wire logic SUPPLY_LOW,
    input wire logic POWERFAIL_COMPARE_IN,
    // Manual reset
    input wire logic MANUAL_RESET_N_IN,
    // Watchdog kick and its float detector
    input wire logic WATCHDOG_KICK_IN,
    input wire logic WATCHDOG_KICK_FLOAT,
    // Reset outputs
    output logic RESET_OUT_N,
    output logic RESET_OUT,
    // Flags
    output logic POWERFAIL_FLAG_N,
    output logic WATCHDOG_TIMEOUT_N
);

    supervisor_pkg::state_t st;
    supervisor_pkg::state_t next_st;
    logic reset_cause;
    logic kick_edge;

    // Reset causes and kick transition detect
    assign reset_cause = SUPPLY_LOW || !MANUAL_RESET_N_IN;
    assign kick_edge = !WATCHDOG_KICK_FLOAT &&
        (WATCHDOG_KICK_IN != st.kick_prev);

    // Next-state logic of the whole block
    always_comb begin
        next_st = st;
        // Total asserted time, saturating at the minimum pulse
        if (st.phase != supervisor_pkg::PH_RUN &&
            st.total_cnt < MIN_PULSE_CYCLES) begin
            next_st.total_cnt = st.total_cnt + supervisor_pkg::CNT_ONE;
        end
        case (st.phase)
            supervisor_pkg::PH_HOLD: begin
                next_st.hold_cnt = supervisor_pkg::CNT_ZERO;
                if (!reset_cause) begin
                    next_st.phase = supervisor_pkg::PH_STRETCH;
                end
            end
            supervisor_pkg::PH_STRETCH: begin
                if (reset_cause) begin
                    // Brownout or button inside the pulse restarts it
                    next_st.phase = supervisor_pkg::PH_HOLD;
                    next_st.hold_cnt = supervisor_pkg::CNT_ZERO;
                end else if (st.hold_cnt >=
                             RELEASE_CYCLES - supervisor_pkg::CNT_ONE &&
                             st.total_cnt >= MIN_PULSE_CYCLES) begin
                    next_st.phase = supervisor_pkg::PH_RUN;
                end else if (st.hold_cnt < RELEASE_CYCLES) begin
                    next_st.hold_cnt = st.hold_cnt +
                        supervisor_pkg::CNT_ONE;
                end
            end
            supervisor_pkg::PH_RUN: begin
                next_st.total_cnt = supervisor_pkg::CNT_ZERO;
                next_st.hold_cnt = supervisor_pkg::CNT_ZERO;
                if (reset_cause) begin
                    // Supply dip or manual press asserts at once
                    next_st.phase = supervisor_pkg::PH_HOLD;
                end
            end
            default: begin
                next_st.phase = supervisor_pkg::PH_HOLD;
            end
        endcase
        // Reset output follows the phase chosen for the next cycle
        next_st.rst_n = (next_st.phase == supervisor_pkg::PH_RUN);
        // Power-fail flag mirrors the auxiliary comparator
        next_st.pf_n = POWERFAIL_COMPARE_IN;
        // Kick history is tracked every cycle, even while the pin floats
        next_st.kick_prev = WATCHDOG_KICK_IN;
        // Watchdog counter
        if (st.phase != supervisor_pkg::PH_RUN) begin
            next_st.wd_armed = 1'b0;
            next_st.wd_cnt = supervisor_pkg::CNT_ZERO;
            next_st.wd_expired = 1'b0;
        end else if (WATCHDOG_KICK_FLOAT) begin
            next_st.wd_armed = 1'b0;
            next_st.wd_cnt = supervisor_pkg::CNT_ZERO;
            next_st.wd_expired = 1'b0;
        end else if (kick_edge) begin
            // Any transition starts or restarts a full countdown
            next_st.wd_armed = 1'b1;
            next_st.wd_cnt = supervisor_pkg::CNT_ZERO;
            next_st.wd_expired = 1'b0;
        end else if (st.wd_armed && !st.wd_expired) begin
            if (st.wd_cnt >=
                WDOG_CYCLES - supervisor_pkg::CNT_ONE) begin
                next_st.wd_expired = 1'b1;
            end else begin
                next_st.wd_cnt = st.wd_cnt + supervisor_pkg::CNT_ONE;
            end
        end
        // Low supply overrides the counter, without a minimum width
        next_st.wdo_n = !(next_st.wd_expired || SUPPLY_LOW);
    end

    // State register with synchronous power-on reset
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            st.phase <= supervisor_pkg::PH_HOLD;
            st.hold_cnt <= supervisor_pkg::CNT_ZERO;
            st.total_cnt <= supervisor_pkg::CNT_ZERO;
            st.rst_n <= 1'b0;
            st.pf_n <= 1'b0;
            st.kick_prev <= 1'b0;
            st.wd_armed <= 1'b0;
            st.wd_cnt <= supervisor_pkg::CNT_ZERO;
            st.wd_expired <= 1'b0;
            st.wdo_n <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs; the high-true reset is the plain complement
    assign RESET_OUT_N = st.rst_n;
    assign RESET_OUT = ~st.rst_n;
    assign POWERFAIL_FLAG_N = st.pf_n;
    assign WATCHDOG_TIMEOUT_N = st.wdo_n;

    // Checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_running_kick;
        st.phase == supervisor_pkg::PH_RUN && kick_edge;
    endsequence

    sequence s_counter_fresh;
        st.wd_armed && st.wd_cnt == supervisor_pkg::CNT_ZERO &&
        !st.wd_expired;
    endsequence

    sequence s_last_count;
        st.phase == supervisor_pkg::PH_RUN && !WATCHDOG_KICK_FLOAT &&
        !kick_edge && st.wd_armed && !st.wd_expired &&
        st.wd_cnt == WDOG_CYCLES - supervisor_pkg::CNT_ONE;
    endsequence

    sequence s_running_count;
        st.phase == supervisor_pkg::PH_RUN && !WATCHDOG_KICK_FLOAT &&
        !kick_edge && st.wd_armed && !st.wd_expired &&
        st.wd_cnt < WDOG_CYCLES - supervisor_pkg::CNT_ONE;
    endsequence

    a_reset_complement:
        assert property (RESET_OUT == !RESET_OUT_N)
        else $error("Reset outputs are not complementary");

    a_supply_holds_reset:
        assert property (SUPPLY_LOW |=> !RESET_OUT_N)
        else $error("Reset released while supply low");

    a_powerdown_assert:
        assert property (SUPPLY_LOW && RESET_OUT_N |=>
            !RESET_OUT_N ##1 !RESET_OUT_N)
        else $error("Power-down did not assert reset");

    a_brownout_pulse:
        assert property ($rose(SUPPLY_LOW) |=> !RESET_OUT_N)
        else $error("Brownout gave no reset pulse");

    a_min_pulse:
        assert property ($rose(RESET_OUT_N) |->
            $past(st.total_cnt) >= MIN_PULSE_CYCLES)
        else $error("Reset pulse shorter than minimum");

    a_powerfail_mirror:
        assert property (1'b1 |=>
            POWERFAIL_FLAG_N == $past(POWERFAIL_COMPARE_IN))
        else $error("Power-fail flag does not follow comparator");

    a_manual_starts:
        assert property (!MANUAL_RESET_N_IN |=> !RESET_OUT_N)
        else $error("Manual reset not honoured");

    a_wdog_expires:
        assert property (s_last_count |=> !WATCHDOG_TIMEOUT_N)
        else $error("Watchdog did not time out");

    a_timeout_holds:
        assert property (st.wd_expired && st.phase == supervisor_pkg::PH_RUN
            && !kick_edge && !WATCHDOG_KICK_FLOAT |=>
            st.wd_expired && !WATCHDOG_TIMEOUT_N)
        else $error("Timeout released without kick");

    a_float_clears:
        assert property (WATCHDOG_KICK_FLOAT |=>
            !st.wd_armed && st.wd_cnt == supervisor_pkg::CNT_ZERO)
        else $error("Counter not cleared while kick floats");

    a_reset_clears_wdog:
        assert property (!RESET_OUT_N |=>
            !st.wd_armed && st.wd_cnt == supervisor_pkg::CNT_ZERO)
        else $error("Counter active during reset");

    a_kick_restarts:
        assert property (s_running_kick and !WATCHDOG_KICK_FLOAT |=>
            s_counter_fresh ##1 (st.wd_cnt <= supervisor_pkg::CNT_ONE))
        else $error("Kick did not restart countdown");

    a_kick_clears_late:
        assert property (s_running_kick ##0 st.wd_armed |=>
            st.wd_cnt == supervisor_pkg::CNT_ZERO &&
            (WATCHDOG_TIMEOUT_N || $past(SUPPLY_LOW)))
        else $error("Further kick left counter running");

    a_supply_forces_wdo:
        assert property (SUPPLY_LOW |=> !WATCHDOG_TIMEOUT_N)
        else $error("Timeout output high while supply low");

    a_wdo_quick_release:
        assert property ($fell(SUPPLY_LOW) && MANUAL_RESET_N_IN |->
            WATCHDOG_TIMEOUT_N == 1'b0 ##1 WATCHDOG_TIMEOUT_N)
        else $error("Timeout output late after supply recovery");

    a_release_delay:
        assert property ($rose(RESET_OUT_N) |->
            $past(st.hold_cnt) >=
            RELEASE_CYCLES - supervisor_pkg::CNT_ONE &&
            $past(st.phase) == supervisor_pkg::PH_STRETCH)
        else $error("Reset released before stretch ended");

    a_kick_releases:
        assert property (s_running_kick ##0 !SUPPLY_LOW |=>
            WATCHDOG_TIMEOUT_N)
        else $error("Kick did not release timeout output");

    a_idle_no_count:
        assert property (st.phase == supervisor_pkg::PH_RUN &&
            !st.wd_armed && !kick_edge |=>
            st.wd_cnt == supervisor_pkg::CNT_ZERO && !st.wd_expired)
        else $error("Watchdog counted before first kick");

    a_count_steps:
        assert property (s_running_count |=>
            st.wd_cnt == $past(st.wd_cnt) + supervisor_pkg::CNT_ONE)
        else $error("Watchdog counter skipped a step");

    a_reset_no_expiry:
        assert property (st.phase != supervisor_pkg::PH_RUN |=>
            !st.wd_expired)
        else $error("Watchdog expired while reset asserted");

    a_recovery_wdo_high:
        assert property (!SUPPLY_LOW &&
            st.phase != supervisor_pkg::PH_RUN |=> WATCHDOG_TIMEOUT_N)
        else $error("Timeout output held low after supply recovery");

    a_cause_restarts:
        assert property (st.phase == supervisor_pkg::PH_STRETCH &&
            reset_cause |=> st.phase == supervisor_pkg::PH_HOLD &&
            !RESET_OUT_N)
        else $error("Cause inside stretch did not restart it");

    a_hold_while_cause:
        assert property (reset_cause |=>
            st.phase == supervisor_pkg::PH_HOLD)
        else $error("Reset released while a cause stands");

    a_por_clears:
        assert property (@(posedge CORE_CLK) disable iff (1'b0)
            !RESET_N |=> st.wd_cnt == supervisor_pkg::CNT_ZERO &&
            st.hold_cnt == supervisor_pkg::CNT_ZERO && !RESET_OUT_N)
        else $error("Power-on reset left counters set");

endmodule // supervisor_reset_watchdog

// ### verification/cpu_side_model.sv
// Purpose: Processor side of the supervisor: kick pin and manual reset wire.
// Assumes: The bench requests single kicks, floating and timeout routing.
// Notes: A floating kick pin shows a level that changes every cycle.
`timescale 1ns/100ps
module cpu_side_model (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic kick_req,
    input wire logic float_req,
    input wire logic mr_req,
    input wire logic route,
    // From supervisor
    input wire logic wdo_n,
    // To supervisor
    output logic kick,
    output logic kick_float,
    output logic mr_n
);
    logic float_d;
    // Toggle on request, or every cycle while floating
    initial kick = 1'b0;
    initial float_d = 1'b0;
    always @(posedge clk) begin
        if (kick_req || float_req) begin
            kick <= ~kick;
        end
        float_d <= float_req;
    end
    // Float flag outlasts the last toggle by one cycle, so the pin is
    // settled before the watchdog looks for edges again
    assign kick_float = float_req | float_d;
    // Timeout routed into manual reset
    assign mr_n = mr_req & (route ? wdo_n : 1'b1);
endmodule // cpu_side_model

// ### verification/supervisor_reset_watchdog_test.sv
// Purpose: Self-checking bench of the supervisor reset and watchdog block.
// Assumes: Shortened counts; powerfail input random on every cycle.
// Notes: Release and timeout edges are accepted within one cycle.
`timescale 1ns/100ps
module supervisor_reset_watchdog_test;
    localparam int REL = 20;
    localparam int MINP = 14;
    localparam int WD = 50;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic supply_low = 1'b1;
    logic pf_in = 1'b1;
    logic pf_exp = 1'b1;
    logic started = 1'b0;
    logic mr_req = 1'b1;
    logic route = 1'b0;
    logic kick_req = 1'b0;
    logic float_req = 1'b0;
    logic kick, kick_float, mr_n, rst_n, rst, pf_n, wdo_n;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 32'h4985d65d;
    int n, m;

    // Clock
    initial forever #12.5 core_clk = ~core_clk;

    supervisor_reset_watchdog #(
        .RELEASE_CYCLES(supervisor_pkg::CNT_W'(REL)),
        .MIN_PULSE_CYCLES(supervisor_pkg::CNT_W'(MINP)),
        .WDOG_CYCLES(supervisor_pkg::CNT_W'(WD))
    ) supervisor_reset_watchdog_inst (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .SUPPLY_LOW(supply_low),
        .POWERFAIL_COMPARE_IN(pf_in), .MANUAL_RESET_N_IN(mr_n),
        .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_FLOAT(kick_float),
        .RESET_OUT_N(rst_n), .RESET_OUT(rst),
        .POWERFAIL_FLAG_N(pf_n), .WATCHDOG_TIMEOUT_N(wdo_n));

    cpu_side_model cpu_side_model_inst (
        .clk(core_clk), .kick_req(kick_req), .float_req(float_req),
        .mr_req(mr_req), .route(route), .wdo_n(wdo_n), .kick(kick),
        .kick_float(kick_float), .mr_n(mr_n));

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
            n_mismatch++;
        end
    endtask

    task results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Expected edge count, one cycle of slack either way
    function logic near(input int k, input int e);
        return (k >= e - 1) && (k <= e + 1);
    endfunction

    task cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    task kick_once;
        @(posedge core_clk) kick_req <= 1'b1;
        @(posedge core_clk) kick_req <= 1'b0;
    endtask

    // One-cycle reset cause: supply low or manual press
    task cause(input bit sup);
        @(posedge core_clk);
        if (sup) supply_low <= 1'b1;
        else mr_req <= 1'b0;
        @(posedge core_clk);
        supply_low <= 1'b0;
        mr_req <= 1'b1;
    endtask

    task wait_for(input logic want, input bit on_wdo, input int lim,
                  output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while ((on_wdo ? wdo_n : rst_n) !== want && k < lim);
    endtask

    // Random powerfail input and its expected flag
    always @(posedge core_clk) begin
        pf_in <= 1'($random(seed));
        pf_exp <= pf_in;
        started <= reset_n;
    end

    // Continuous flag and complement checks
    always @(negedge core_clk) begin
        if (started) begin
            check("powerfail flag", pf_n, pf_exp);
            check("reset complement", rst, !rst_n);
        end
    end

    // Watchdog against a hang
    initial begin
        #1000000;
        n_mismatch++;
        results;
    end

    initial begin
        cyc(16);
        reset_n <= 1'b1;
        cyc(30);
        @(negedge core_clk);
        check("reset at power-up", rst_n, 1'b0);
        check("timeout at low supply", wdo_n, 1'b0);
        @(posedge core_clk) supply_low <= 1'b0;
        wait_for(1'b1, 1'b1, 6, n);
        check("timeout release", n, 2);
        wait_for(1'b1, 1'b0, 200, m);
        check("power-up release", near(n + m, REL + 2), 1'b1);
        $display("test power-up done");
        cyc(WD + 20);
        @(negedge core_clk);
        check("no countdown before kick", wdo_n, 1'b1);
        kick_once;
        wait_for(1'b0, 1'b1, WD + 20, n);
        check("timeout length", near(n, WD + 2), 1'b1);
        cyc(10);
        @(negedge core_clk);
        check("timeout held", wdo_n, 1'b0);
        kick_once;
        wait_for(1'b1, 1'b1, 6, n);
        check("timeout cleared by kick", near(n, 2), 1'b1);
        for (int i = 0; i < 8; i++) begin
            kick_once;
            cyc(i == 0 ? 0 : 5 + $unsigned($random(seed)) % (WD - 10));
            @(negedge core_clk);
            check("kick restarts count", wdo_n, 1'b1);
        end
        $display("test watchdog done");
        @(posedge core_clk) float_req <= 1'b1;
        cyc(2 * WD);
        @(negedge core_clk);
        check("float stops count", wdo_n, 1'b1);
        @(posedge core_clk) float_req <= 1'b0;
        cyc(WD + 10);
        @(negedge core_clk);
        check("float clears count", wdo_n, 1'b1);
        $display("test float done");
        // Manual press, supply brownout, brownout during a pulse
        for (int i = 0; i < 3; i++) begin
            if (i == 2) begin
                cause(1'b1);
                cyc(5);
            end
            cause(i != 0);
            wait_for(1'b0, 1'b0, 6, n);
            check("reset asserts", n, 1);
            check("timeout on supply", wdo_n, i == 0);
            wait_for(1'b1, 1'b0, 200, m);
            check("pulse length", near(n + m, REL + 2), 1'b1);
            check("minimum pulse", n + m >= MINP, 1'b1);
        end
        $display("test reset causes done");
        kick_once;
        @(posedge core_clk) mr_req <= 1'b0;
        cyc(3);
        kick_once;
        cyc(WD + 10);
        @(negedge core_clk);
        check("count held in reset", wdo_n, 1'b1);
        @(posedge core_clk) mr_req <= 1'b1;
        wait_for(1'b1, 1'b0, 200, n);
        cyc(WD + 10);
        @(negedge core_clk);
        check("count disarmed by reset", wdo_n, 1'b1);
        $display("test reset hold done");
        @(posedge core_clk) route <= 1'b1;
        kick_once;
        wait_for(1'b0, 1'b0, WD + 20, n);
        check("timeout resets system", near(n, WD + 3), 1'b1);
        @(posedge core_clk) route <= 1'b0;
        wait_for(1'b1, 1'b0, 200, n);
        $display("test routing done");
        results;
    end
endmodule // supervisor_reset_watchdog_test
